// [rtl/pmrv_top.sv]
// Management serial slave and register view of the two integrated PHYs
//
// Overview of operation
// - Control bit 3, reset 0, disables automatic crossover while set.
// - Control bit 2, reset 0, suppresses far-end fault detection while set.
// - Control bit 1, reset 0, stops the PHY transmitter while set.
// - Control bit 0, reset 0, switches the port indicator LEDs off while set.
// - Transmit-disable bit shares storage with switch register 29/45 bit 6.
// - Status bits 14 to 11 always read one: all four speed modes.
// - Status bit 15 always reads zero: no four-pair mode.
// - Status bit 0 always reads zero: no extended registers.
// - Status bit 5 reads one once auto-negotiation has finished.
// - Status bit 4 reads one while a far-end fault is seen.
// - Status bit 3 reads one: PHY can auto-negotiate.
// - Status bit 2 reads one while link is up, zero while down.
// - Link-up bit follows switch status register 30/46 bit 5.
// - Offsets 2 and 3 return the fixed upper and lower identifier words.
// - Advertisement bit 10, reset 1, offers pause capability.
// - Advertisement bit 8, reset 1, offers 100 Mb/s full duplex.
// - Advertisement bit 7, reset 1, offers 100 Mb/s half duplex.
// - Advertisement bit 6, reset 1, offers 10 Mb/s full duplex.
// - Advertisement bit 5, reset 1, offers 10 Mb/s half duplex.
// - PHY address 1 selects the first PHY, 2 the second; offset 1 is status.
`timescale 1ns/10ps
`include "pmrv_map.svh"

module pmrv_top #(
    parameter logic [15:0] IDENT_UPPER = 16'h0ABC, // Arbitrary value
    parameter logic [15:0] IDENT_LOWER = 16'h0DEF  // Arbitrary value
) (
    // Clock, enable and reset
    input  wire logic                          CLK,
    input  wire logic                          CE,
    input  wire logic                          SRST,
    // Management serial pins
    input  wire logic                          MDC,
    input  wire logic                          MDIO_IN,
    output logic                               MDIO_OUT,
    output logic                               MDIO_OE,
    // Switch-side alias of transmit disable, index 0 is the first PHY
    input  wire logic [1:0]                    SW_TXDIS_WR,
    input  wire logic [1:0]                    SW_TXDIS_VAL,
    // Switch-core status per PHY
    input  wire pmrv_pkg::pmrv_status_type [1:0] PHY_STATUS,
    // Settings per PHY
    output pmrv_pkg::pmrv_cfg_type [1:0]       PHY_CFG
);

    // ======================================================================
    // Pin synchronisers
    // MDC and MDIO come from the station's clock, so both are retimed.
    // The first stage is read by the second stage only.
    logic mdc_meta;
    logic mdc_sync;
    logic mdc_prev;
    logic mdio_meta;
    logic mdio_sync;

    // Two-stage capture plus one stage for edge detection
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mdc_meta  <= 1'h0;
            mdc_sync  <= 1'h0;
            mdc_prev  <= 1'h0;
            mdio_meta <= 1'h1;
            mdio_sync <= 1'h1;
        end else if (CE) begin
            mdc_meta  <= MDC;
            mdc_sync  <= mdc_meta;
            mdc_prev  <= mdc_sync;
            mdio_meta <= MDIO_IN;
            mdio_sync <= mdio_meta;
        end
    end

    // Station drives data before its rising edge, so sample there
    wire mdc_rise = mdc_sync & ~mdc_prev;

    // ======================================================================
    // Frame state
    pmrv_pkg::pmrv_state_type state;
    pmrv_pkg::pmrv_state_type next_state;
    logic [5:0]  pre_cnt;
    logic [5:0]  next_pre_cnt;
    logic [4:0]  bit_cnt;
    logic [4:0]  next_bit_cnt;
    logic [11:0] hdr;
    logic [11:0] next_hdr;
    logic [15:0] shift;
    logic [15:0] next_shift;
    logic        is_read;
    logic        next_is_read;
    logic        sel;
    logic        next_sel;
    logic [4:0]  reg_addr;
    logic [4:0]  next_reg_addr;
    logic        next_mdio_out;
    logic        next_mdio_oe;

    // ======================================================================
    // Header decode
    // The last header bit is taken straight from the sampled pin so the
    // decision is ready on the edge that completes the header.
    wire [11:0] hdr_now    = {hdr[10:0], mdio_sync};
    wire [1:0]  op_now     = hdr_now[11:10];
    wire [4:0]  phy_now    = hdr_now[9:5];
    wire [4:0]  reg_now    = hdr_now[4:0];
    wire        hit_first  = (phy_now == `PMRV_PHY_ADDR_FIRST);
    wire        hit_second = (phy_now == `PMRV_PHY_ADDR_SECOND);
    wire        phy_hit    = hit_first | hit_second;
    wire        op_read    = (op_now == `PMRV_OP_READ);
    wire        op_write   = (op_now == `PMRV_OP_WRITE);
    wire        pre_full   = (pre_cnt == `PMRV_PREAMBLE_LEN);

    // ======================================================================
    // Register access
    logic [15:0] rd_word [2];
    wire  [15:0] rd_sel   = sel ? rd_word[1] : rd_word[0];
    wire         commit   = mdc_rise & (state == pmrv_pkg::PMRV_WDATA)
                            & (bit_cnt == `PMRV_DATA_LAST);
    wire  [15:0] wr_word  = {shift[14:0], mdio_sync};
    wire  [1:0]  wr_en    = {commit & sel, commit & ~sel};

    // ======================================================================
    // Frame sequencer
    // Advances only on MDC rising edges. A frame with a bad start or op code,
    // or that names another PHY, drops back to preamble hunting, so no stray write lands.
    always_comb begin
        next_state    = state;
        next_pre_cnt  = pre_cnt;
        next_bit_cnt  = bit_cnt;
        next_hdr      = hdr;
        next_shift    = shift;
        next_is_read  = is_read;
        next_sel      = sel;
        next_reg_addr = reg_addr;
        next_mdio_out = MDIO_OUT;
        next_mdio_oe  = MDIO_OE;
        if (mdc_rise) begin
            case (state)
                pmrv_pkg::PMRV_PREAMBLE: begin
                    if (mdio_sync) begin
                        // Saturate so long preambles are fine
                        if (!pre_full) begin
                            next_pre_cnt = pre_cnt + 6'h01;
                        end
                    end else if (pre_full) begin
                        next_state   = pmrv_pkg::PMRV_START;
                        next_pre_cnt = 6'h00;
                    end else begin
                        next_pre_cnt = 6'h00;
                    end
                end
                pmrv_pkg::PMRV_START: begin
                    if (mdio_sync) begin
                        next_state   = pmrv_pkg::PMRV_FIELDS;
                        next_bit_cnt = 5'h00;
                    end else begin
                        next_state = pmrv_pkg::PMRV_PREAMBLE;
                    end
                end
                pmrv_pkg::PMRV_FIELDS: begin
                    next_hdr = hdr_now;
                    if (bit_cnt == `PMRV_HDR_LAST) begin
                        next_bit_cnt  = 5'h00;
                        next_sel      = hit_second;
                        next_reg_addr = reg_now;
                        next_is_read  = op_read;
                        if (phy_hit && (op_read || op_write)) begin
                            next_state = pmrv_pkg::PMRV_TURN;
                        end else begin
                            next_state = pmrv_pkg::PMRV_PREAMBLE;
                        end
                    end else begin
                        next_bit_cnt = bit_cnt + 5'h01;
                    end
                end
                pmrv_pkg::PMRV_TURN: begin
                    if (bit_cnt == 5'h00) begin
                        // Second turnaround bit is a driven zero on reads
                        next_bit_cnt = 5'h01;
                        if (is_read) begin
                            next_mdio_oe  = 1'h1;
                            next_mdio_out = 1'h0;
                        end
                    end else begin
                        next_bit_cnt = 5'h00;
                        if (is_read) begin
                            next_state    = pmrv_pkg::PMRV_RDATA;
                            next_shift    = rd_sel;
                            next_mdio_out = rd_sel[15];
                        end else begin
                            next_state = pmrv_pkg::PMRV_WDATA;
                        end
                    end
                end
                pmrv_pkg::PMRV_RDATA: begin
                    if (bit_cnt == `PMRV_DATA_LAST) begin
                        // Station has taken the last bit; let go of the line
                        next_mdio_oe  = 1'h0;
                        next_mdio_out = 1'h0;
                        next_state    = pmrv_pkg::PMRV_PREAMBLE;
                        next_bit_cnt  = 5'h00;
                    end else begin
                        next_mdio_out = shift[14];
                        next_shift    = {shift[14:0], 1'h0};
                        next_bit_cnt  = bit_cnt + 5'h01;
                    end
                end
                pmrv_pkg::PMRV_WDATA: begin
                    next_shift = wr_word;
                    if (bit_cnt == `PMRV_DATA_LAST) begin
                        next_state   = pmrv_pkg::PMRV_PREAMBLE;
                        next_bit_cnt = 5'h00;
                    end else begin
                        next_bit_cnt = bit_cnt + 5'h01;
                    end
                end
                default: begin
                    next_state   = pmrv_pkg::PMRV_PREAMBLE;
                    next_mdio_oe = 1'h0;
                end
            endcase
        end
    end

    // Frame state registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state    <= pmrv_pkg::PMRV_PREAMBLE;
            pre_cnt  <= 6'h00;
            bit_cnt  <= 5'h00;
            hdr      <= 12'h000;
            shift    <= 16'h0000;
            is_read  <= 1'h0;
            sel      <= 1'h0;
            reg_addr <= 5'h00;
            MDIO_OUT <= 1'h0;
            MDIO_OE  <= 1'h0;
        end else if (CE) begin
            state    <= next_state;
            pre_cnt  <= next_pre_cnt;
            bit_cnt  <= next_bit_cnt;
            hdr      <= next_hdr;
            shift    <= next_shift;
            is_read  <= next_is_read;
            sel      <= next_sel;
            reg_addr <= next_reg_addr;
            MDIO_OUT <= next_mdio_out;
            MDIO_OE  <= next_mdio_oe;
        end
    end

    // ======================================================================
    // Register sets of the two PHYs
    // Index 0 answers PHY address 1, index 1 answers PHY address 2.
    pmrv_phy_regs #(
        .IDENT_UPPER (IDENT_UPPER),
        .IDENT_LOWER (IDENT_LOWER)
    ) u_regs_first (
        .clk          (CLK),
        .ce           (CE),
        .srst         (SRST),
        .wr_en        (wr_en[0]),
        .reg_addr     (reg_addr),
        .wr_data      (wr_word),
        .sw_txdis_wr  (SW_TXDIS_WR[0]),
        .sw_txdis_val (SW_TXDIS_VAL[0]),
        .status       (PHY_STATUS[0]),
        .cfg          (PHY_CFG[0]),
        .rd_data      (rd_word[0])
    );

    pmrv_phy_regs #(
        .IDENT_UPPER (IDENT_UPPER),
        .IDENT_LOWER (IDENT_LOWER)
    ) u_regs_second (
        .clk          (CLK),
        .ce           (CE),
        .srst         (SRST),
        .wr_en        (wr_en[1]),
        .reg_addr     (reg_addr),
        .wr_data      (wr_word),
        .sw_txdis_wr  (SW_TXDIS_WR[1]),
        .sw_txdis_val (SW_TXDIS_VAL[1]),
        .status       (PHY_STATUS[1]),
        .cfg          (PHY_CFG[1]),
        .rd_data      (rd_word[1])
    );

endmodule : pmrv_top

// [include/pmrv_map.svh]
// Offsets, field positions, fixed values and frame constants of the PHY register view
`ifndef PMRV_MAP_SVH
`define PMRV_MAP_SVH

// ==========================================================================
// Management addressing
`define PMRV_PHY_ADDR_FIRST   5'h01
`define PMRV_PHY_ADDR_SECOND  5'h02

// ==========================================================================
// Register offsets
`define PMRV_REG_CONTROL      5'h00
`define PMRV_REG_STATUS       5'h01
`define PMRV_REG_IDENT_UPPER  5'h02
`define PMRV_REG_IDENT_LOWER  5'h03
`define PMRV_REG_ADVERTISE    5'h04
`define PMRV_REG_PARTNER      5'h05

// ==========================================================================
// Basic control fields
`define PMRV_CTL_MDIX_OFF     3
`define PMRV_CTL_FEF_OFF      2
`define PMRV_CTL_TX_OFF       1
`define PMRV_CTL_IND_OFF      0
`define PMRV_CTL_RESET        1'h0

// ==========================================================================
// Advertisement fields
`define PMRV_ADV_PAUSE        10
`define PMRV_ADV_RSVD         9
`define PMRV_ADV_100F         8
`define PMRV_ADV_100H         7
`define PMRV_ADV_10F          6
`define PMRV_ADV_10H          5
`define PMRV_ADV_ABIL_RESET   1'h1
`define PMRV_ADV_RSVD_RESET   1'h0
`define PMRV_ADV_SELECTOR     5'h01

// ==========================================================================
// Fixed status fields
`define PMRV_STS_FOUR_PAIR    1'h0
`define PMRV_STS_SPEED_ABLE   4'hF
`define PMRV_STS_AN_ABLE      1'h1
`define PMRV_STS_EXTENDED     1'h0

// ==========================================================================
// Management frame
`define PMRV_PREAMBLE_LEN     6'h20
`define PMRV_OP_READ          2'h2
`define PMRV_OP_WRITE         2'h1
`define PMRV_HDR_LAST         5'h0B
`define PMRV_DATA_LAST        5'h0F

`endif

// [include/pmrv_pkg.sv]
// Types shared by the PHY management register view
package pmrv_pkg;

    // Per-PHY settings driven out to the PHY and switch core
    typedef struct packed {
        logic mdix_off;
        logic fef_off;
        logic tx_off;
        logic indicator_off;
        logic adv_pause;
        logic adv_100_full;
        logic adv_100_half;
        logic adv_10_full;
        logic adv_10_half;
    } pmrv_cfg_type;

    // Per-PHY state reported by the switch core
    typedef struct packed {
        logic        autoneg_done;
        logic        far_end_fault;
        logic        link_up;
        logic [12:0] partner_ability;
    } pmrv_status_type;

    // Serial frame states
    typedef enum logic [2:0] {
        PMRV_PREAMBLE,
        PMRV_START,
        PMRV_FIELDS,
        PMRV_TURN,
        PMRV_RDATA,
        PMRV_WDATA
    } pmrv_state_type;

endpackage : pmrv_pkg

// [rtl/pmrv_phy_regs.sv]
// Register set of one PHY: control, status, identifier, advertisement, partner
`timescale 1ns/10ps
`include "pmrv_map.svh"

module pmrv_phy_regs #(
    parameter logic [15:0] IDENT_UPPER = 16'h0ABC, // Arbitrary value
    parameter logic [15:0] IDENT_LOWER = 16'h0DEF  // Arbitrary value
) (
    // Clock, enable and reset
    input  wire logic                    clk,
    input  wire logic                    ce,
    input  wire logic                    srst,
    // Management write port
    input  wire logic                    wr_en,
    input  wire logic [4:0]              reg_addr,
    input  wire logic [15:0]             wr_data,
    // Switch-side alias of the transmit-disable bit
    input  wire logic                    sw_txdis_wr,
    input  wire logic                    sw_txdis_val,
    // Status in, settings and read data out
    input  wire pmrv_pkg::pmrv_status_type status,
    output pmrv_pkg::pmrv_cfg_type       cfg,
    output logic [15:0]                  rd_data
);

    logic adv_rsvd;

    // ======================================================================
    // Write decode
    wire wr_ctl = wr_en & (reg_addr == `PMRV_REG_CONTROL);
    wire wr_adv = wr_en & (reg_addr == `PMRV_REG_ADVERTISE);

    // Settings storage; other registers have no storage so writes vanish
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg.mdix_off      <= `PMRV_CTL_RESET;
            cfg.fef_off       <= `PMRV_CTL_RESET;
            cfg.tx_off        <= `PMRV_CTL_RESET;
            cfg.indicator_off <= `PMRV_CTL_RESET;
            cfg.adv_pause     <= `PMRV_ADV_ABIL_RESET;
            cfg.adv_100_full  <= `PMRV_ADV_ABIL_RESET;
            cfg.adv_100_half  <= `PMRV_ADV_ABIL_RESET;
            cfg.adv_10_full   <= `PMRV_ADV_ABIL_RESET;
            cfg.adv_10_half   <= `PMRV_ADV_ABIL_RESET;
            adv_rsvd          <= `PMRV_ADV_RSVD_RESET;
        end else if (ce) begin
            if (wr_ctl) begin
                cfg.mdix_off      <= wr_data[`PMRV_CTL_MDIX_OFF];
                cfg.fef_off       <= wr_data[`PMRV_CTL_FEF_OFF];
                cfg.indicator_off <= wr_data[`PMRV_CTL_IND_OFF];
            end
            // Management write wins over a same-cycle switch write
            if (wr_ctl) begin
                cfg.tx_off <= wr_data[`PMRV_CTL_TX_OFF];
            end else if (sw_txdis_wr) begin
                cfg.tx_off <= sw_txdis_val;
            end
            if (wr_adv) begin
                cfg.adv_pause    <= wr_data[`PMRV_ADV_PAUSE];
                cfg.adv_100_full <= wr_data[`PMRV_ADV_100F];
                cfg.adv_100_half <= wr_data[`PMRV_ADV_100H];
                cfg.adv_10_full  <= wr_data[`PMRV_ADV_10F];
                cfg.adv_10_half  <= wr_data[`PMRV_ADV_10H];
                adv_rsvd         <= wr_data[`PMRV_ADV_RSVD];
            end
        end
    end

    // ======================================================================
    // Read words; fixed fields are constants so writes cannot move them
    wire        fef_seen = status.far_end_fault & ~cfg.fef_off;
    wire [15:0] ctl_word = {12'h000, cfg.mdix_off, cfg.fef_off, cfg.tx_off,
                            cfg.indicator_off};
    wire [15:0] sts_word = {`PMRV_STS_FOUR_PAIR, `PMRV_STS_SPEED_ABLE,
                            5'h00, status.autoneg_done, fef_seen,
                            `PMRV_STS_AN_ABLE, status.link_up,
                            1'h0, `PMRV_STS_EXTENDED};
    wire [15:0] adv_word = {5'h00, cfg.adv_pause, adv_rsvd, cfg.adv_100_full,
                            cfg.adv_100_half, cfg.adv_10_full, cfg.adv_10_half,
                            `PMRV_ADV_SELECTOR};
    wire [15:0] lpa_word = {3'h0, status.partner_ability};

    // Register select; unsupported offsets read as zero
    assign rd_data = (reg_addr == `PMRV_REG_CONTROL)     ? ctl_word    :
                     (reg_addr == `PMRV_REG_STATUS)      ? sts_word    :
                     (reg_addr == `PMRV_REG_IDENT_UPPER) ? IDENT_UPPER :
                     (reg_addr == `PMRV_REG_IDENT_LOWER) ? IDENT_LOWER :
                     (reg_addr == `PMRV_REG_ADVERTISE)   ? adv_word    :
                     (reg_addr == `PMRV_REG_PARTNER)     ? lpa_word    :
                     16'h0000;

endmodule : pmrv_phy_regs

// [verification/pmrv_top_props.sv]
// Concurrent checks on the pins of the PHY register view
`timescale 1ns/10ps
module pmrv_top_props (
    // Clock, enable and reset
    input wire logic                         CLK,
    input wire logic                         CE,
    input wire logic                         SRST,
    // Management pins
    input wire logic                         MDC,
    input wire logic                         MDIO_OUT,
    input wire logic                         MDIO_OE,
    // Switch alias and settings
    input wire logic [1:0]                   SW_TXDIS_WR,
    input wire logic [1:0]                   SW_TXDIS_VAL,
    input wire pmrv_pkg::pmrv_cfg_type [1:0] PHY_CFG
);
    logic       mdc_q;
    logic [3:0] since_rise;
    // ========================================
    // Cycles since MDC rose, saturating over long idles
    always_ff @(posedge CLK) begin
        mdc_q      <= MDC;
        since_rise <= (SRST || since_rise == 4'hF) ? 4'hF : since_rise + 4'h1;
        if (MDC && !mdc_q) begin
            since_rise <= 4'h0;
        end
    end
    sequence s_after_rise;
        since_rise inside {[2:7]};
    endsequence
    sequence s_turn_low;
        (MDIO_OE && !MDIO_OUT) [*4];
    endsequence
    AST_RST_CFG: assert property (@(posedge CLK) SRST && CE |=> PHY_CFG == {2{9'h01F}} && !MDIO_OE)
        else $error("reset values wrong");
    AST_ALIAS_FIRST: assert property (@(posedge CLK) disable iff (SRST) CE && SW_TXDIS_WR[0] |=> PHY_CFG[0].tx_off == $past(SW_TXDIS_VAL[0]))
        else $error("first alias write lost");
    AST_ALIAS_SECOND: assert property (@(posedge CLK) disable iff (SRST) CE && SW_TXDIS_WR[1] |=> PHY_CFG[1].tx_off == $past(SW_TXDIS_VAL[1]))
        else $error("second alias write lost");
    AST_OE_RISE: assert property (@(posedge CLK) disable iff (SRST) $rose(MDIO_OE) |-> s_after_rise)
        else $error("drive began off MDC rise");
    AST_TURN_ZERO: assert property (@(posedge CLK) disable iff (SRST) $rose(MDIO_OE) |-> s_turn_low)
        else $error("turnaround bit not low");
    AST_OE_HOLD: assert property (@(posedge CLK) disable iff (SRST) $rose(MDIO_OE) |=> MDIO_OE [*8])
        else $error("drive released too early");
    AST_OUT_TIMING: assert property (@(posedge CLK) disable iff (SRST) MDIO_OE && $changed(MDIO_OUT) |-> s_after_rise)
        else $error("data moved off MDC rise");
    AST_OE_FALL: assert property (@(posedge CLK) disable iff (SRST) $fell(MDIO_OE) |-> s_after_rise)
        else $error("drive ended off MDC rise");
    AST_READ_KEEPS_CFG: assert property (@(posedge CLK) disable iff (SRST) MDIO_OE && !(|SW_TXDIS_WR) |=> $stable(PHY_CFG))
        else $error("settings moved during a read");
endmodule : pmrv_top_props

bind pmrv_top pmrv_top_props u_props (.CLK(CLK), .CE(CE), .SRST(SRST), .MDC(MDC),
    .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .SW_TXDIS_WR(SW_TXDIS_WR),
    .SW_TXDIS_VAL(SW_TXDIS_VAL), .PHY_CFG(PHY_CFG));

// [verification/pmrv_station.sv]
// Management station model driving the serial clock and data pin
`timescale 1ns/10ps
module pmrv_station (
    // Clock
    input  wire logic clk,
    // Block pins
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output logic      mdc,
    output logic      mdio_in
);
    logic sta_oe = 1'b0, sta_d = 1'b1;
    // ========================================
    // Wire level; pull-up when nobody drives
    assign mdio_in = sta_oe ? sta_d : (mdio_oe ? mdio_out : 1'b1);
    initial mdc = 1'b0;
    // One frame, 9 CLK per bit; a preamble under 32 is refused
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, input int pre, output logic [15:0] rd);
        logic [63:0] f;
        f  = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
        rd = 16'hFFFF;
        for (int i = 32 - pre; i < 64; i++) begin
            @(posedge clk);
            mdc    <= 1'b0;
            sta_oe <= (op == 2'h1) || (i < 46);
            sta_d  <= f[63 - i];
            repeat (4) @(posedge clk);
            if (i >= 48) begin
                rd[63 - i] = mdio_in;
            end
            mdc <= 1'b1;
            repeat (4) @(posedge clk);
        end
        @(posedge clk);
        mdc    <= 1'b0;
        sta_oe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : xfer
endmodule : pmrv_station

// [verification/tb_pmrv_top.sv]
// Self-checking testbench of the PHY register view
`timescale 1ns/10ps
module tb_pmrv_top;
    localparam logic [15:0] ID_HI = 16'h2468; // Arbitrary value
    localparam logic [15:0] ID_LO = 16'h9BDF; // Arbitrary value
    logic                            clk = 1'b0, srst = 1'b1, mdc, mdio_in, mdio_out, mdio_oe;
    logic [1:0]                      sw_wr = 2'h0, sw_val = 2'h0;
    pmrv_pkg::pmrv_status_type [1:0] sts    = '0;
    pmrv_pkg::pmrv_cfg_type [1:0]    cfg;
    logic [15:0]                     rd;
    int                              n_errors = 0, compares = 0;
    // ========================================
    // Clock, block and station
    always #25 clk = ~clk;
    pmrv_top #(.IDENT_UPPER(ID_HI), .IDENT_LOWER(ID_LO)) dut_u (.CLK(clk), .CE(1'b1),
        .SRST(srst), .MDC(mdc), .MDIO_IN(mdio_in), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
        .SW_TXDIS_WR(sw_wr), .SW_TXDIS_VAL(sw_val), .PHY_STATUS(sts), .PHY_CFG(cfg));
    pmrv_station u_sta (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
        .mdio_in(mdio_in));
    // ========================================
    // Shared helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
        u_sta.xfer(2'h1, phy, ra, wd, 32, rd);
    endtask : wr
    task automatic rdr(input logic [4:0] phy, input logic [4:0] ra);
        u_sta.xfer(2'h2, phy, ra, 16'h0000, 32, rd);
    endtask : rdr
    function automatic logic [15:0] sexp(logic d, logic f, logic l, logic fo);
        return {1'h0, 4'hF, 5'h00, d, f & ~fo, 1'h1, l, 2'h0};
    endfunction : sexp
    // ========================================
    // Scenarios
    task automatic t_reset;
        for (int p = 0; p < 2; p++) begin
            chk("cfg", 16'h001F, {7'h00, cfg[p]});
            rdr(5'(p + 1), 5'h00);
            chk("ctl", 16'h0000, rd);
            rdr(5'(p + 1), 5'h01);
            chk("status", sexp(0, 0, 0, 0), rd);
            rdr(5'(p + 1), 5'h02);
            chk("id hi", ID_HI, rd);
            rdr(5'(p + 1), 5'h03);
            chk("id lo", ID_LO, rd);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_ctrl_adv;
        wr(5'h01, 5'h00, 16'hFFFF);
        rdr(5'h01, 5'h00);
        chk("ctl", 16'h000F, rd);
        chk("cfg1", 16'h01FF, {7'h00, cfg[0]});
        chk("cfg2", 16'h001F, {7'h00, cfg[1]});
        wr(5'h01, 5'h00, 16'h0005);
        chk("cfg1", 16'h00BF, {7'h00, cfg[0]});
        wr(5'h01, 5'h00, 16'h000A);
        chk("cfg1", 16'h015F, {7'h00, cfg[0]});
        wr(5'h01, 5'h00, 16'h0000);
        wr(5'h02, 5'h04, 16'h0000);
        chk("cfg2", 16'h0000, {7'h00, cfg[1]});
        rdr(5'h02, 5'h04);
        chk("adv", 16'h0001, rd);
        wr(5'h02, 5'h04, 16'hFFFF);
        rdr(5'h02, 5'h04);
        chk("adv", 16'h07E1, rd);
        $display("test ctrl and adv done");
    endtask : t_ctrl_adv
    task automatic t_status;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            sts[1] <= {k[2:0], 13'h1ABC};
            rdr(5'h02, 5'h01);
            chk("status", sexp(k[2], k[1], k[0], 0), rd);
        end
        wr(5'h02, 5'h00, 16'h0004);
        wr(5'h02, 5'h01, 16'h0000);
        rdr(5'h02, 5'h01);
        chk("status", sexp(1, 1, 1, 1), rd);
        rdr(5'h02, 5'h05);
        chk("partner", 16'h1ABC, rd);
        wr(5'h02, 5'h00, 16'h0000);
        $display("test status done");
    endtask : t_status
    task automatic t_alias;
        @(posedge clk);
        sw_wr  <= 2'h2;
        sw_val <= 2'h2;
        @(posedge clk);
        sw_wr  <= 2'h0;
        @(posedge clk);
        chk("alias", 16'h0001, {15'h0000, cfg[1].tx_off});
        rdr(5'h02, 5'h00);
        chk("ctl", 16'h0002, rd);
        wr(5'h02, 5'h00, 16'h0000);
        chk("alias", 16'h0000, {15'h0000, cfg[1].tx_off});
        $display("test alias done");
    endtask : t_alias
    task automatic t_refuse;
        wr(5'h03, 5'h00, 16'hFFFE); // Ends low
        u_sta.xfer(2'h1, 5'h01, 5'h00, 16'hFFFF, 31, rd);
        u_sta.xfer(2'h3, 5'h01, 5'h00, 16'hFFFF, 32, rd);
        wr(5'h01, 5'h02, 16'h0000);
        chk("cfg1", 16'h001F, {7'h00, cfg[0]});
        rdr(5'h03, 5'h00);
        chk("other addr", 16'hFFFF, rd);
        rdr(5'h01, 5'h02);
        chk("id hi", ID_HI, rd);
        rdr(5'h01, 5'h06);
        chk("unmapped", 16'h0000, rd);
        $display("test refusals done");
    endtask : t_refuse
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // ========================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_ctrl_adv();
        t_status();
        t_alias();
        t_refuse();
        summarize();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("[FAIL] run expected end seen timeout");
        summarize();
    end
endmodule : tb_pmrv_top
